// >>> hdl/dipc_pkg.sv
// constants and shared types for the dual issue pipeline control block
// assumes a single core clock; no software-visible registers
package dipc_pkg;

  localparam int IQ_DEPTH   = 12;
  localparam int CQ_DEPTH   = 14;
  localparam int ISQ_DEPTH  = 4;
  localparam int MUL_STAGES = 4;
  localparam int NUM_ARCH   = 32;
  localparam int AW         = 5;
  localparam int BO_W       = 5;
  localparam int NUM_UNITS  = 4;

  typedef enum logic [1:0] {
    dipc_u_simple = 2'h0,
    dipc_u_mul    = 2'h1,
    dipc_u_branch = 2'h2,
    dipc_u_mem    = 2'h3
  } dipc_unit_t;

  typedef enum logic [1:0] {
    dipc_ph_run   = 2'h0,
    dipc_ph_drain = 2'h1
  } dipc_phase_t;

  typedef struct packed {
    dipc_unit_t    unit;
    logic [AW-1:0] dest;
    logic [AW-1:0] src;
    logic          pred;
  } dipc_ins_t;

endpackage : dipc_pkg

// >>> hdl/dipc_multiply_pipe.sv
// four stage multiply pipe: takes one start per cycle, reports finish of its tag
// assumes flush clears every multiply in flight (all are younger than the flush point)
`timescale 1ns/1ps
module dipc_multiply_pipe #(
  parameter int STAGES = dipc_pkg::MUL_STAGES,
  parameter int TW     = 4
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          start,
  input  wire logic [TW-1:0] start_tag,
  input  wire logic          flush,
  output logic               done,
  output logic [TW-1:0]      done_tag
);

  typedef struct packed {
    logic [STAGES-1:0]         v;
    logic [STAGES-1:0][TW-1:0] tag;
  } dipc_mul_state_t;

  dipc_mul_state_t r_reg;
  dipc_mul_state_t r_next;

  // ****************************************
  // stage shift
  // ****************************************
  always_comb begin
    r_next = r_reg;
    r_next.v[0]   = start;
    r_next.tag[0] = start_tag;
    for (int s = 1; s < STAGES; s++) begin
      r_next.v[s]   = r_reg.v[s-1];
      r_next.tag[s] = r_reg.tag[s-1];
    end
    if (flush) begin
      r_next.v = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign done     = r_reg.v[STAGES-1];
  assign done_tag = r_reg.tag[STAGES-1];

endmodule : dipc_multiply_pipe

// >>> hdl/dipc_pipeline_ctrl.sv
// pipeline control: fetch queue, decode/dispatch, issue, reservation, completion, write back
// assumes execution units report finish by tag and drop their work when flush is high
// Contract
// - static branch option hint bits never predict
// - prediction disabled means every branch not taken
// - mispredict completion redirects fetch, squashes wrong path
// - correctly predicted branch lets followers complete
// - complete in order from two oldest entries
// - only finished instructions may complete
// - completion never passes a pending exception
// - completion removes the retirement queue entry
// - dispatch needs issue queue and retirement space
// - decode renames operands and dispatches to queues
// - dispatch hands order tracking to retirement queue
// - retirement entry allocated with issue queue entry
// - finish marks result held in rename register
// - issue reads operands, routes to matching unit
// - rename results forwarded to younger consumers
// - reservation station holds issued, not ready instructions
// - fetch queue keeps program order
// - multiply pipe four stages, one per cycle
// - write back one cycle after completion
// - write back buffer never flushed
// - older results written before taking exception
// - busy multi-cycle unit stalls its followers
`timescale 1ns/1ps
module dipc_pipeline_ctrl #(
  parameter int IQ_DEPTH  = dipc_pkg::IQ_DEPTH,
  parameter int CQ_DEPTH  = dipc_pkg::CQ_DEPTH,
  parameter int ISQ_DEPTH = dipc_pkg::ISQ_DEPTH,
  parameter int TW        = $clog2(CQ_DEPTH),
  parameter int IW        = $clog2(IQ_DEPTH),
  parameter int SW        = $clog2(ISQ_DEPTH + 1)
) (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic                        fetch_valid,
  input  wire dipc_pkg::dipc_unit_t        fetch_unit,
  input  wire logic [dipc_pkg::AW-1:0]     fetch_dest,
  input  wire logic [dipc_pkg::AW-1:0]     fetch_src,
  input  wire logic [dipc_pkg::BO_W-1:0]   fetch_branch_options_operand,
  input  wire logic                        predict_taken_dyn,
  input  wire logic                        dynamic_predict_enable,
  input  wire logic [dipc_pkg::NUM_UNITS-1:0] unit_busy,
  input  wire logic                        finish_valid,
  input  wire logic [TW-1:0]               finish_tag,
  input  wire logic                        finish_excp,
  input  wire logic                        finish_taken,
  output logic                             fetch_ready,
  output logic                             fetch_redirect,
  output logic                             exec_valid,
  output dipc_pkg::dipc_unit_t             exec_unit,
  output logic [TW-1:0]                    exec_tag,
  output logic [dipc_pkg::AW-1:0]          exec_src,
  output logic [TW-1:0]                    exec_src_tag,
  output logic                             exec_src_rename,
  output logic [1:0]                       wb_valid,
  output logic [1:0][dipc_pkg::AW-1:0]     wb_dest,
  output logic [1:0]                       retire_count,
  output logic                             flush,
  output logic                             exception_taken
);

  typedef struct packed {
    logic                valid;
    logic                issued;
    logic                finished;
    logic                excp;
    logic                mispred;
    logic                src_ren;
    dipc_pkg::dipc_ins_t ins;
    logic [TW-1:0]       src_tag;
  } dipc_cq_t;

  typedef struct packed {
    dipc_pkg::dipc_ins_t [IQ_DEPTH-1:0]          iq;
    logic [IW-1:0]                               iq_head;
    logic [IW:0]                                 iq_cnt;
    dipc_cq_t [CQ_DEPTH-1:0]                     cq;
    logic [TW-1:0]                               cq_head;
    logic [TW:0]                                 cq_cnt;
    logic [dipc_pkg::NUM_UNITS-1:0][SW-1:0]      isq_cnt;
    logic [dipc_pkg::NUM_UNITS-1:0]              rs_valid;
    logic [dipc_pkg::NUM_UNITS-1:0][TW-1:0]      rs_tag;
    logic [dipc_pkg::NUM_ARCH-1:0]               map_valid;
    logic [dipc_pkg::NUM_ARCH-1:0][TW-1:0]       map_tag;
    dipc_pkg::dipc_phase_t                       ph;
    logic                                        fetch_ready;
    logic                                        fetch_redirect;
    logic                                        exec_valid;
    dipc_pkg::dipc_unit_t                        exec_unit;
    logic [TW-1:0]                               exec_tag;
    logic [dipc_pkg::AW-1:0]                     exec_src;
    logic [TW-1:0]                               exec_src_tag;
    logic                                        exec_src_rename;
    logic [1:0]                                  wb_valid;
    logic [1:0][dipc_pkg::AW-1:0]                wb_dest;
    logic [1:0]                                  retire_count;
    logic                                        flush;
    logic                                        exception_taken;
  } dipc_state_t;

  dipc_state_t   r_reg;
  dipc_state_t   r_next;
  logic          mul_done;
  logic [TW-1:0] mul_done_tag;

  // ring index helpers; depths need not be powers of two
  function automatic logic [TW-1:0] cq_at(input int p);
    return TW'((p >= CQ_DEPTH) ? p - CQ_DEPTH : p);
  endfunction : cq_at

  function automatic logic [IW-1:0] iq_at(input int p);
    return IW'((p >= IQ_DEPTH) ? p - IQ_DEPTH : p);
  endfunction : iq_at

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [TW-1:0]       tag;
    logic [TW-1:0]       h1;
    logic [TW-1:0]       tail;
    logic [1:0]          done;
    logic                c0;
    logic                c1;
    logic                disp;
    logic                push;
    logic                launch;
    logic                found;
    logic                excp_now;
    dipc_cq_t            e;
    dipc_pkg::dipc_ins_t ins;
    tag      = '0;
    h1       = cq_at(int'(r_reg.cq_head) + 1);
    tail     = cq_at(int'(r_reg.cq_head) + int'(r_reg.cq_cnt));
    done     = 2'h0;
    launch   = 1'b0;
    found    = 1'b0;
    excp_now = 1'b0;
    e        = '0;
    ins      = r_reg.iq[r_reg.iq_head];
    r_next   = r_reg;
    r_next.fetch_redirect  = 1'b0;
    r_next.flush           = 1'b0;
    r_next.exception_taken = 1'b0;
    r_next.exec_valid      = 1'b0;
    r_next.wb_valid        = 2'h0;

    // finish: result now sits in the rename slot of its tag
    if (finish_valid && r_reg.cq[finish_tag].valid && r_reg.cq[finish_tag].issued) begin
      r_next.cq[finish_tag].finished = 1'b1;
      r_next.cq[finish_tag].excp     = finish_excp;
      r_next.cq[finish_tag].mispred  = (r_reg.cq[finish_tag].ins.unit == dipc_pkg::dipc_u_branch)
                                       && (finish_taken != r_reg.cq[finish_tag].ins.pred);
    end
    if (mul_done && r_reg.cq[mul_done_tag].valid) begin
      r_next.cq[mul_done_tag].finished = 1'b1;
    end

    // ****************************************
    // completion and write back
    // ****************************************
    c0 = (r_reg.ph == dipc_pkg::dipc_ph_run) && (r_reg.cq_cnt != '0)
         && r_reg.cq[r_reg.cq_head].finished && !r_reg.cq[r_reg.cq_head].excp;
    // a mispredicted branch completes alone so nothing of the wrong path slips out
    c1 = c0 && !r_reg.cq[r_reg.cq_head].mispred && (r_reg.cq_cnt > 1)
         && r_reg.cq[h1].finished && !r_reg.cq[h1].excp && !r_reg.cq[h1].mispred;
    for (int k = 0; k < 2; k++) begin
      tag = (k == 0) ? r_reg.cq_head : h1;
      if ((k == 0) ? c0 : c1) begin
        r_next.cq[tag].valid = 1'b0;
        r_next.wb_valid[k]   = 1'b1;
        r_next.wb_dest[k]    = r_reg.cq[tag].ins.dest;
        if (r_reg.map_valid[r_reg.cq[tag].ins.dest]
            && (r_reg.map_tag[r_reg.cq[tag].ins.dest] == tag)) begin
          r_next.map_valid[r_reg.cq[tag].ins.dest] = 1'b0;
        end
        // consumers now read the architected copy, so the slot may be reused safely
        for (int j = 0; j < CQ_DEPTH; j++) begin
          if (r_reg.cq[j].src_ren && (r_reg.cq[j].src_tag == tag)) begin
            r_next.cq[j].src_ren = 1'b0;
          end
        end
      end
    end
    done                = {1'b0, c0} + {1'b0, c1};
    r_next.retire_count = done;
    r_next.cq_head      = cq_at(int'(r_reg.cq_head) + int'(done));

    // ****************************************
    // decode and dispatch
    // ****************************************
    disp = (r_reg.iq_cnt != '0) && (int'(r_reg.isq_cnt[ins.unit]) < ISQ_DEPTH)
           && (int'(r_reg.cq_cnt) < CQ_DEPTH);
    if (disp) begin
      r_next.cq[tail].valid    = 1'b1;
      r_next.cq[tail].issued   = 1'b0;
      r_next.cq[tail].finished = 1'b0;
      r_next.cq[tail].excp     = 1'b0;
      r_next.cq[tail].mispred  = 1'b0;
      r_next.cq[tail].ins      = ins;
      r_next.cq[tail].src_ren  = r_next.map_valid[ins.src];
      r_next.cq[tail].src_tag  = r_next.map_tag[ins.src];
      r_next.map_valid[ins.dest] = 1'b1;
      r_next.map_tag[ins.dest]   = tail;
      r_next.isq_cnt[ins.unit]   = r_next.isq_cnt[ins.unit] + 1'b1;
      r_next.iq_head = iq_at(int'(r_reg.iq_head) + 1);
    end

    // ****************************************
    // reservation stations to execute
    // ****************************************
    for (int u = 0; u < dipc_pkg::NUM_UNITS; u++) begin
      e = r_reg.cq[r_reg.rs_tag[u]];
      if (!launch && r_reg.rs_valid[u] && !unit_busy[u]
          && (!e.src_ren || r_reg.cq[e.src_tag].finished)) begin
        launch                 = 1'b1;
        r_next.rs_valid[u]     = 1'b0;
        r_next.exec_valid      = 1'b1;
        r_next.exec_unit       = e.ins.unit;
        r_next.exec_tag        = r_reg.rs_tag[u];
        r_next.exec_src        = e.ins.src;
        r_next.exec_src_tag    = e.src_tag;
        r_next.exec_src_rename = e.src_ren;
      end
    end

    // ****************************************
    // issue: oldest waiting entry whose station is free
    // ****************************************
    for (int i = 0; i < CQ_DEPTH; i++) begin
      tag = cq_at(int'(r_reg.cq_head) + i);
      if (!found && (i < int'(r_reg.cq_cnt)) && r_reg.cq[tag].valid && !r_reg.cq[tag].issued
          && !r_next.rs_valid[r_reg.cq[tag].ins.unit]) begin
        found = 1'b1;
        r_next.cq[tag].issued = 1'b1;
        r_next.rs_valid[r_reg.cq[tag].ins.unit] = 1'b1;
        r_next.rs_tag[r_reg.cq[tag].ins.unit]   = tag;
        r_next.isq_cnt[r_reg.cq[tag].ins.unit]  =
          r_next.isq_cnt[r_reg.cq[tag].ins.unit] - 1'b1;
      end
    end

    // ****************************************
    // fetch into the instruction queue
    // ****************************************
    // the cycle that shows the redirect still carries wrong path words, so drop them
    push = fetch_valid && r_reg.fetch_ready && !r_reg.fetch_redirect;
    if (push) begin
      tag = TW'(0);
      r_next.iq[iq_at(int'(r_reg.iq_head) + int'(r_reg.iq_cnt))] = '{
        unit: fetch_unit, dest: fetch_dest, src: fetch_src,
        // hint bits of fetch_branch_options_operand are deliberately unused
        pred: (fetch_unit == dipc_pkg::dipc_u_branch) && dynamic_predict_enable
              && predict_taken_dyn};
    end
    r_next.cq_cnt = r_reg.cq_cnt - {{(TW-1){1'b0}}, done} + {{TW{1'b0}}, disp};
    r_next.iq_cnt = r_reg.iq_cnt - {{IW{1'b0}}, disp} + {{IW{1'b0}}, push};

    // ****************************************
    // exception ordering and flush
    // ****************************************
    case (r_reg.ph)
      dipc_pkg::dipc_ph_run: begin
        if ((r_reg.cq_cnt != '0) && r_reg.cq[r_reg.cq_head].finished
            && r_reg.cq[r_reg.cq_head].excp) begin
          r_next.ph = dipc_pkg::dipc_ph_drain;
        end
      end
      dipc_pkg::dipc_ph_drain: begin
        if (r_reg.wb_valid == 2'h0) begin
          excp_now  = 1'b1;
          r_next.ph = dipc_pkg::dipc_ph_run;
        end
      end
      default: begin
        r_next.ph = dipc_pkg::dipc_ph_run;
      end
    endcase

    // write back fields are left alone here: those results are architected already
    if ((c0 && r_reg.cq[r_reg.cq_head].mispred) || excp_now) begin
      r_next.flush           = 1'b1;
      r_next.fetch_redirect  = 1'b1;
      r_next.exception_taken = excp_now;
      r_next.exec_valid      = 1'b0;
      r_next.iq_cnt          = '0;
      r_next.cq_cnt          = '0;
      r_next.isq_cnt         = '0;
      r_next.rs_valid        = '0;
      r_next.map_valid       = '0;
      for (int j = 0; j < CQ_DEPTH; j++) begin
        r_next.cq[j].valid = 1'b0;
      end
    end
    r_next.fetch_ready = (int'(r_next.iq_cnt) < IQ_DEPTH);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************
  // multiply pipe
  // ****************************************
  dipc_multiply_pipe #(
    .STAGES (dipc_pkg::MUL_STAGES),
    .TW     (TW)
  ) u_multiply_pipe (
    .clk       (clk),
    .rst_b     (rst_b),
    .start     (r_reg.exec_valid && (r_reg.exec_unit == dipc_pkg::dipc_u_mul)),
    .start_tag (r_reg.exec_tag),
    .flush     (r_reg.flush),
    .done      (mul_done),
    .done_tag  (mul_done_tag)
  );

  assign fetch_ready     = r_reg.fetch_ready;
  assign fetch_redirect  = r_reg.fetch_redirect;
  assign exec_valid      = r_reg.exec_valid;
  assign exec_unit       = r_reg.exec_unit;
  assign exec_tag        = r_reg.exec_tag;
  assign exec_src        = r_reg.exec_src;
  assign exec_src_tag    = r_reg.exec_src_tag;
  assign exec_src_rename = r_reg.exec_src_rename;
  assign wb_valid        = r_reg.wb_valid;
  assign wb_dest         = r_reg.wb_dest;
  assign retire_count    = r_reg.retire_count;
  assign flush           = r_reg.flush;
  assign exception_taken = r_reg.exception_taken;

endmodule : dipc_pipeline_ctrl

// >>> tb/dipc_pipeline_ctrl_props.sv
// assertions on the pipeline control top ports
// assumes one core clock and a synchronous active-low reset
`timescale 1ns/1ps
module dipc_pipeline_ctrl_props (
  input wire logic                             clk,
  input wire logic                             rst_b,
  input wire logic [dipc_pkg::NUM_UNITS-1:0]   unit_busy,
  input wire logic                             exec_valid,
  input wire dipc_pkg::dipc_unit_t             exec_unit,
  input wire logic [1:0]                       wb_valid,
  input wire logic [1:0]                       retire_count,
  input wire logic                             flush,
  input wire logic                             fetch_redirect,
  input wire logic                             exception_taken
);
  // ************
  // properties
  // ************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  logic [dipc_pkg::NUM_UNITS-1:0] busy_d;

  // launch decision is made one cycle ahead of exec_valid
  always_ff @(posedge clk) busy_d <= unit_busy;

  busy_stall_a: assert property (exec_valid |-> !busy_d[exec_unit])
    else $error("launch to a busy unit");
  lane_order_a: assert property (wb_valid[1] |-> wb_valid[0])
    else $error("younger lane wrote back alone");
  retire_match_a: assert property (retire_count == {1'b0, wb_valid[0]} + {1'b0, wb_valid[1]})
    else $error("retire count differs from write back lanes");
  count_bound_a: assert property (retire_count != 2'h3)
    else $error("more than two retired in a cycle");
  redirect_pair_a: assert property (fetch_redirect == flush)
    else $error("redirect without flush or the reverse");
  excp_drain_a: assert property (exception_taken |-> flush && $past(wb_valid) == 2'h0)
    else $error("exception taken before older writes drained");
  excp_noretire_a: assert property (exception_taken |-> retire_count == 2'h0 && wb_valid == 2'h0)
    else $error("retirement beside exception");
  flush_quiet_a: assert property (flush |=> (!exec_valid && wb_valid == 2'h0)[*3])
    else $error("work survived a flush");
endmodule : dipc_pipeline_ctrl_props

bind dipc_pipeline_ctrl dipc_pipeline_ctrl_props u_props (
  .clk, .rst_b, .unit_busy, .exec_valid, .exec_unit, .wb_valid,
  .retire_count, .flush, .fetch_redirect, .exception_taken
);

// >>> tb/dipc_fetch_source.sv
// instruction cache model: hands words over in program order
// assumes the bench pushes words through the push task after reset
`timescale 1ns/1ps
module dipc_fetch_source (
  input  wire logic           clk,
  input  wire logic           rst_b,
  input  wire logic           slow,
  input  wire logic           fetch_ready,
  input  wire logic           fetch_redirect,
  output logic                fetch_valid,
  output dipc_pkg::dipc_unit_t fetch_unit,
  output logic [4:0]          fetch_dest,
  output logic [4:0]          fetch_src,
  output logic [4:0]          fetch_branch_options_operand,
  output logic                predict_taken_dyn
);
  // ************
  // word queue
  // ************
  dipc_pkg::dipc_ins_t q[$];
  dipc_pkg::dipc_ins_t last;
  logic                taken;

  task automatic push(input dipc_pkg::dipc_ins_t w);
    q.push_back(w);
  endtask : push

  initial begin
    taken = 1'b0;
    last = '0;
    fetch_valid = 1'b0;
    {fetch_dest, fetch_src, fetch_branch_options_operand, predict_taken_dyn} = '0;
    fetch_unit = dipc_pkg::dipc_u_simple;
  end

  always @(posedge clk) taken <= rst_b && fetch_valid && fetch_ready && !fetch_redirect;

  always @(negedge clk) begin
    if (taken) void'(q.pop_front());
    if (fetch_redirect) q.delete();
    // hint bits are noise the core must ignore
    fetch_branch_options_operand <= 5'($urandom);
    // an offered word is held until taken; slow mode delays new offers
    if (q.size() > 0 && ((fetch_valid && !taken) || !slow || $urandom_range(2) == 0)) begin
      fetch_valid <= 1'b1;
      last = q[0];
    end else begin
      fetch_valid <= 1'b0;
      last = dipc_pkg::dipc_ins_t'(~last);
    end
    fetch_unit <= last.unit;
    fetch_dest <= last.dest;
    fetch_src <= last.src;
    predict_taken_dyn <= last.pred;
  end
endmodule : dipc_fetch_source

// >>> tb/dual_issue_pipeline_control_tb_top.sv
// self-checking bench: queue model of program-order write back
// assumes the fetch source partner and the bound checker
`timescale 1ns/1ps
module dual_issue_pipeline_control_tb_top;
  logic                 clk, rst_b, slow, fetch_valid, predict_taken_dyn;
  logic                 dynamic_predict_enable, finish_valid, finish_excp, finish_taken;
  logic                 fetch_ready, fetch_redirect, exec_valid, exec_src_rename;
  logic                 flush, exception_taken;
  dipc_pkg::dipc_unit_t fetch_unit, exec_unit;
  logic [4:0]           fetch_dest, fetch_src, fetch_branch_options_operand, exec_src;
  logic [3:0]           unit_busy, finish_tag, exec_tag, exec_src_tag;
  logic [1:0]           wb_valid, retire_count;
  logic [1:0][4:0]      wb_dest;
  int                   errors, samples_checked, fin_div, idx, seed_dummy, j, k;
  int                   ret_total, test_base;
  bit                   busy_on, br_taken, excp_mem, last_mul, fire;
  dipc_pkg::dipc_ins_t  tw[$];
  bit                   seen_flush, seen_excp, saw_full, mul_b2b;
  logic [4:0]           exp_q[$];
  logic [5:0]           pend[$];
  logic [5:0]           ent;
  logic [2:0]           br_cases[4] = '{3'h7, 3'h3, 3'h4, 3'h6};

  dipc_fetch_source src (
    .clk, .rst_b, .slow, .fetch_ready, .fetch_redirect, .fetch_valid, .fetch_unit,
    .fetch_dest, .fetch_src, .fetch_branch_options_operand, .predict_taken_dyn
  );
  dipc_pipeline_ctrl dut (
    .clk, .rst_b, .fetch_valid, .fetch_unit, .fetch_dest, .fetch_src,
    .fetch_branch_options_operand, .predict_taken_dyn, .dynamic_predict_enable,
    .unit_busy, .finish_valid, .finish_tag, .finish_excp, .finish_taken, .fetch_ready,
    .fetch_redirect, .exec_valid, .exec_unit, .exec_tag, .exec_src, .exec_src_tag,
    .exec_src_rename, .wb_valid, .wb_dest, .retire_count, .flush, .exception_taken
  );

  // ************
  // helpers
  // ************
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (e !== g) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, e, g);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  // ************
  // monitor and execution units
  // ************
  always @(negedge clk) begin
    if (rst_b) begin
      if (exec_valid === 1'b1) begin
        // tags run round the retirement ring in program order from the oldest live word
        j = ret_total - test_base + (int'(exec_tag) - ret_total % dipc_pkg::CQ_DEPTH
            + dipc_pkg::CQ_DEPTH) % dipc_pkg::CQ_DEPTH;
        k = j - 1;
        while (k >= 0 && j < tw.size() && tw[k].dest != tw[j].src) k--;
        if (j >= tw.size()) begin
          chk("exec_tag_range", 0, 1);
        end else begin
          chk("exec_unit", tw[j].unit, exec_unit);
          chk("exec_src", tw[j].src, exec_src);
          chk("exec_src_rename", k >= ret_total - test_base, exec_src_rename);
          if (k >= ret_total - test_base) begin
            chk("exec_src_tag", (test_base + k) % dipc_pkg::CQ_DEPTH, exec_src_tag);
          end
        end
        // the multiply pipe finishes by itself, other units answer by tag
        if (exec_unit != dipc_pkg::dipc_u_mul) pend.push_back({exec_unit, exec_tag});
        else if (last_mul) mul_b2b = 1'b1;
      end
      last_mul = exec_valid === 1'b1 && exec_unit == dipc_pkg::dipc_u_mul;
      for (int l = 0; l < 2; l++) begin
        if (wb_valid[l] === 1'b1 && exp_q.size() == 0) chk("wb_extra", 0, 1);
        else if (wb_valid[l] === 1'b1) chk("wb_dest", exp_q.pop_front(), wb_dest[l]);
        if (wb_valid[l] === 1'b1) ret_total++;
      end
      if (flush === 1'b1) begin
        seen_flush = 1'b1;
        pend.delete();
      end
      if (exception_taken === 1'b1) seen_excp = 1'b1;
      if (fetch_ready === 1'b0) saw_full = 1'b1;
    end
    fire = rst_b === 1'b1 && flush !== 1'b1 && pend.size() > 0
           && $urandom_range(fin_div - 1) == 0;
    finish_valid <= fire;
    if (fire) begin
      idx = $urandom_range(pend.size() - 1);
      ent = pend[idx];
      pend.delete(idx);
      finish_tag <= ent[3:0];
      finish_excp <= ent[5:4] == 2'h3 && excp_mem;
      finish_taken <= ent[5:4] == 2'h2 && br_taken;
    end
    unit_busy <= busy_on ? 4'($urandom) & 4'($urandom) : 4'h0;
  end

  // spec: 0 mixed, 1 branch second, 2 faulting load third, 3 all multiply
  task automatic run_test(input string name, input int n, input int spec, input bit pr);
    dipc_pkg::dipc_ins_t w;
    bit                  stop;
    bit                  want;
    stop = 1'b0;
    want = 1'b0;
    tw.delete();
    test_base = ret_total;
    {seen_flush, seen_excp, saw_full, mul_b2b} = 4'h0;
    excp_mem = spec == 2;
    for (int i = 0; i < n; i++) begin
      {w.dest, w.src} = 10'($urandom);
      w.pred = pr;
      case (spec)
        0: w.unit = dipc_pkg::dipc_unit_t'(2'($urandom) & 2'h1 | 2'($urandom) & 2'h3 & 2'h1);
        1: w.unit = (i == 1) ? dipc_pkg::dipc_u_branch : dipc_pkg::dipc_u_simple;
        2: w.unit = (i == 2) ? dipc_pkg::dipc_u_mem : dipc_pkg::dipc_u_simple;
        default: w.unit = dipc_pkg::dipc_u_mul;
      endcase
      if (spec == 0 && i % 3 == 2) w.unit = dipc_pkg::dipc_u_mem;
      if (!stop) begin
        if (w.unit == dipc_pkg::dipc_u_mem && excp_mem) want = 1'b1;
        else exp_q.push_back(w.dest);
        if (w.unit == dipc_pkg::dipc_u_branch &&
            (dynamic_predict_enable && w.pred) != br_taken) want = 1'b1;
        stop = want;
      end
      src.push(w);
      tw.push_back(w);
    end
    for (int c = 0; exp_q.size() > 0 || seen_flush != want; c++) begin
      if (c == 1500) begin
        errors++;
        $display("MISMATCH %s wait expected done seen timeout", name);
        wrap_up();
      end
      @(negedge clk);
    end
    repeat (20) @(negedge clk);
    chk("flush_seen", want, seen_flush);
    chk("exception_seen", want && spec == 2, seen_excp);
    $display("test %s done", name);
  endtask : run_test

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    seed_dummy = $urandom(32'h841C97C6);
    {rst_b, slow, busy_on, br_taken, excp_mem, last_mul} = '0;
    {finish_valid, finish_excp, finish_taken, finish_tag, unit_busy} = '0;
    dynamic_predict_enable = 1'b1;
    fin_div = 2;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    run_test("plain", 16, 0, 1'b0);
    busy_on = 1'b1;
    slow = 1'b1;
    run_test("busy_slow", 16, 0, 1'b1);
    busy_on = 1'b0;
    slow = 1'b0;
    run_test("mul_stream", 8, 3, 1'b0);
    chk("mul_back_to_back", 1, mul_b2b);
    fin_div = 16;
    run_test("full", 32, 0, 1'b0);
    chk("fetch_held", 1, saw_full);
    fin_div = 2;
    for (int k = 0; k < 4; k++) begin
      dynamic_predict_enable = br_cases[k][2];
      br_taken = br_cases[k][0];
      run_test("branch", 4, 1, br_cases[k][1]);
    end
    dynamic_predict_enable = 1'b1;
    run_test("exception", 4, 2, 1'b0);
    wrap_up();
  end
endmodule : dual_issue_pipeline_control_tb_top
